// ===== core/rdc_pkg.sv
// Purpose: shared constants and carriers for the request descriptor checker
// Assumes: 32-bit APB register bus, 28-bit host memory addresses
// Notes: tags carry first in the upper bit and last in the lower bit
package rdc_pkg;
   localparam int ADDR_W = 28;
   localparam int APB_AW = 8;
   localparam int NCH = 2;
   // register byte offsets
   localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFF_RQPTR0 = 8'h04;
   localparam logic [APB_AW-1:0] OFF_RQPTR1 = 8'h08;
   localparam logic [APB_AW-1:0] OFF_ODLPTR = 8'h0C;
   localparam logic [APB_AW-1:0] OFF_ATTN = 8'h10;
   localparam logic [APB_AW-1:0] OFF_STAT = 8'h14;
   localparam int CTRL_GO = 0;
   localparam int CTRL_CLM = 2;
   localparam int CTRL_BCN = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [ADDR_W-1:0] PTR_RST = 28'h000_0000;
   // descriptor stepping in host memory
   localparam logic [ADDR_W-1:0] DESC_STEP = 28'h000_0008;
   localparam logic [ADDR_W-1:0] WORD_STEP = 28'h000_0004;
   // descriptor field positions
   localparam int TRC_LSB = 8;
   localparam int CCL_LSB = 12;
   localparam int SIZE_LSB = 16;
   localparam int UID_LSB = 24;
   localparam int TAG_LSB = 30;
   localparam int LOC_LSB = 2;
   localparam int CNT_W = 13;
   localparam int CCL_END = 0;
   localparam int CCL_INT = 1;
   localparam int CCL_FULL = 2;
   localparam int CCL_RPT = 3;
   localparam int TAG_F = 1;
   localparam int TAG_L = 0;
   localparam logic [1:0] TAG_LAST = 2'h1;
   localparam logic [1:0] LOC_ZERO = 2'h0;
   localparam logic [3:0] TRC_NONE = 4'h0;
   localparam logic [3:0] TRC_SYNC = 4'h4;
   localparam logic [7:0] SIZE_ZERO = 8'h00;
   localparam logic [7:0] FRAME_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
   // request status codes
   localparam logic [3:0] RS_NONE = 4'h0;
   localparam logic [3:0] RS_OK = 4'h6;
   localparam logic [3:0] RS_EXC_MIN = 4'h7;
   localparam logic [3:0] RS_BAD_RINGOP = 4'hA;
   localparam logic [3:0] RS_CONSIST = 4'hE;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [APB_AW-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } mem_rd_s;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [CNT_W-1:0] byte_count;
      logic frame_end;
      logic last_frame;
   } odu_s;

   typedef struct packed {
      logic valid;
      logic channel;
      logic [3:0] request_status;
      logic [5:0] user_identification;
      logic full;
   } cnf_s;
endpackage

// ===== core/request_descriptor_checker.sv
// Purpose: request descriptor interpreter for two request channels
// Assumes: host memory answers reads on clk_sys; MAC side is same-clock logic
// Notes: one engine serves channel 0 before channel 1
// Functional notes
// - serve descriptors until last part reached
// - first tag must follow last or only
// - first descriptor with class zero is inconsistent
// - first descriptor with invalid confirmation class fails
// - inconsistency aborts and reports request status
// - latch class from first, drive to MAC
// - incompatible class sets channel unserviceable bit
// - confirmation class latched from first only
// - end, intermediate and full confirmation bits
// - repeat bit resends first frame
// - zero-count first latches, fetches next, no ready
// - zero-count last captures token unless immediate, asserts final
// - user identification taken from first descriptor
// - list address from location bits 27 to 2
// - output descriptor tag marks only/first/middle/last
// - decode timer, synchronous and immediate classes
// - ring events block restricted and synchronous service
// - restricted dialogue waits for non-restricted token
// - immediate service from claim, beacon or data
// - output descriptors give byte address and count
// - zero count on first output descriptor fails
// - inconsistency reported as consistency failure code
// - request pointer steps per fetched descriptor
// - list pointer steps per fetched output descriptor that passes its checks
`timescale 1ns/1ps
module request_descriptor_checker
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire rdc_pkg::apb_req_s apb_in,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output rdc_pkg::mem_rd_s mem_rd,
   input wire logic mem_rd_ack,
   input wire logic [31:0] mem_rdata,
   output rdc_pkg::odu_s odu_out,
   input wire logic odu_ready,
   output rdc_pkg::cnf_s cnf_out,
   output logic [3:0] request_class_outputs,
   output logic request_ready,
   output logic final_frame_signal,
   output logic tht_enable,
   output logic claim_request,
   output logic beacon_request,
   output logic imm_from_claim,
   output logic imm_from_beacon,
   input wire logic token_captured,
   input wire logic nonrestricted_token_passed,
   input wire logic ring_operational,
   input wire logic beacon_received_bit,
   input wire logic claim_received_bit,
   input wire logic other_mac_frame_bit
);
   import rdc_pkg::*;

   typedef enum logic [8:0] {
      ST_IDLE = 9'b0_0000_0001,
      ST_RQ0 = 9'b0_0000_0010,
      ST_RQ1 = 9'b0_0000_0100,
      ST_RCHK = 9'b0_0000_1000,
      ST_TOKEN = 9'b0_0001_0000,
      ST_OD0 = 9'b0_0010_0000,
      ST_OD1 = 9'b0_0100_0000,
      ST_OSEND = 9'b0_1000_0000,
      ST_CNF = 9'b1_0000_0000
   } state_e;

   // class decoders: restricted on the latched class, reserved on the fetched one, immediate on both
   function automatic logic cls_restricted(input logic [3:0] c);
      return c[3] && (c[1:0] != 2'h0);
   endfunction
   function automatic logic cls_immediate(input logic [3:0] c);
      return (c[3:2] == 2'h1) && (c[1:0] != 2'h0);
   endfunction
   function automatic logic cls_reserved(input logic [3:0] c);
      return c[3:1] == 3'h1;
   endfunction

   logic [1:0] rst_sync_r;
   logic rst_n;
   state_e state_r;
   logic ch_r;
   logic [ADDR_W-1:0] fetch_addr_r;
   logic [31:0] w0_r;
   logic [1:0] req_tag_r;
   logic [ADDR_W-1:0] req_loc_r;
   logic [3:0] trc_r;
   logic [3:0] ccl_r;
   logic [5:0] uid_r;
   logic [7:0] frames_r;
   logic [ADDR_W-1:0] odl_ptr_r;
   logic [ADDR_W-1:0] odl_start_r;
   logic [CNT_W-1:0] od_cnt_r;
   logic [1:0] prev_req_tag_r [NCH];
   logic [1:0] prev_od_tag_r [NCH];
   logic [ADDR_W-1:0] rq_ptr_r [NCH];
   logic obj_active_r;
   logic token_held_r;
   logic zero_end_r;
   logic nr_seen_r;
   logic final_r;
   logic [3:0] rs_r;
   logic [3:0] last_rs_r;
   logic [3:0] ctrl_r;
   logic [NCH-1:0] usr_r;
   odu_s odu_r;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn) rst_sync_r <= 2'h0;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // descriptor field decode
   wire [1:0] tag_in = mem_rdata[TAG_LSB +: 2];
   wire [3:0] trc_in = w0_r[TRC_LSB +: 4];
   wire [3:0] ccl_in = w0_r[CCL_LSB +: 4];
   wire [7:0] size_in = w0_r[SIZE_LSB +: 8];
   wire req_first = req_tag_r[TAG_F];
   wire req_end = req_tag_r[TAG_L];
   wire prev_end = prev_req_tag_r[ch_r][TAG_L];
   wire req_seq_err = req_first != prev_end;
   wire cls_err = req_first && (trc_in == TRC_NONE);
   wire ccl_bad = (ccl_in[CCL_FULL:CCL_END] == 3'h0) || (ccl_in[CCL_INT] && !ccl_in[CCL_END]);
   wire cnf_err = req_first && ccl_bad;
   wire req_err = req_seq_err || cls_err || cnf_err;
   // the class that rules this descriptor: fresh on a first, latched otherwise
   wire [3:0] eff_trc = req_first ? trc_in : trc_r;
   wire incompat = cls_reserved(trc_in) || (cls_immediate(trc_in) && ring_operational);
   wire eff_imm = cls_immediate(eff_trc);
   wire od_first = tag_in[TAG_F];
   wire [CNT_W-1:0] cnt_in = mem_rdata[CNT_W-1:0];
   // the count sits in word 0, so it is the latched copy by the time the tag arrives
   wire od_err = (od_first != prev_od_tag_r[ch_r][TAG_L]) ||
      (od_first && od_cnt_r == CNT_ZERO);
   wire repeat_on = ccl_r[CCL_RPT];
   wire go_ch = ctrl_r[CTRL_GO + 32'(ch_r)];
   wire od_last_frame = repeat_on ? !go_ch : (frames_r == FRAME_ONE) && req_end;

   // servicing gates toward the MAC
   wire blk_restr = cls_restricted(trc_r) &&
      (beacon_received_bit || claim_received_bit || other_mac_frame_bit);
   wire blk_sync = (trc_r == TRC_SYNC) && beacon_received_bit;
   wire blk_begin = trc_r[3] && (trc_r[1:0] == 2'h1) && !nr_seen_r;
   wire blocked = blk_restr || blk_sync || blk_begin;
   wire take_token = (state_r == ST_TOKEN) && token_captured && !blocked;
   wire rq_inc = (state_r == ST_RQ1) && mem_rd_ack;
   wire od_inc = (state_r == ST_OD1) && mem_rd_ack && !od_err;
   wire usr_set = (state_r == ST_RCHK) && !req_err && req_first && incompat;
   wire go_clr = (state_r == ST_CNF);
   wire cnf_write = (rs_r >= RS_EXC_MIN) || ccl_r[CCL_END];

   // MAC facing outputs
   assign request_class_outputs = obj_active_r ? trc_r : TRC_NONE;
   assign request_ready = (state_r == ST_TOKEN) && !zero_end_r && !blocked;
   assign final_frame_signal = final_r || (odu_r.valid && odu_r.last_frame);
   assign tht_enable = obj_active_r && ((trc_r[3:2] == 2'h2) || (trc_r == 4'h1));
   assign claim_request = ctrl_r[CTRL_CLM];
   assign beacon_request = ctrl_r[CTRL_BCN];
   // claim takes precedence; neither forces a state change on the ring
   assign imm_from_claim = obj_active_r && cls_immediate(trc_r) && claim_request;
   assign imm_from_beacon = obj_active_r && cls_immediate(trc_r) && !claim_request &&
      beacon_request;
   assign mem_rd.valid = (state_r == ST_RQ0) || (state_r == ST_RQ1) ||
      (state_r == ST_OD0) || (state_r == ST_OD1);
   assign mem_rd.addr = fetch_addr_r;
   assign odu_out = odu_r;
   assign cnf_out.valid = go_clr && cnf_write;
   assign cnf_out.channel = ch_r;
   assign cnf_out.request_status = rs_r;
   assign cnf_out.user_identification = uid_r;
   assign cnf_out.full = ccl_r[CCL_FULL];

   // apb slave: zero wait states, unmapped offsets answer with an error
   wire apb_acc = apb_in.psel && apb_in.penable;
   wire apb_wr = apb_acc && apb_in.pwrite;
   wire [APB_AW-1:0] pa = apb_in.paddr;
   wire mapped = (pa == OFF_CTRL) || (pa == OFF_RQPTR0) || (pa == OFF_RQPTR1) ||
      (pa == OFF_ODLPTR) || (pa == OFF_ATTN) || (pa == OFF_STAT);
   assign pready = 1'b1;
   assign pslverr = apb_acc && !mapped;
   assign prdata = (pa == OFF_CTRL) ? {28'h000_0000, ctrl_r} :
      (pa == OFF_RQPTR0) ? {4'h0, rq_ptr_r[0]} :
      (pa == OFF_RQPTR1) ? {4'h0, rq_ptr_r[1]} :
      (pa == OFF_ODLPTR) ? {4'h0, odl_ptr_r} :
      (pa == OFF_ATTN) ? {30'h0000_0000, usr_r} :
      (pa == OFF_STAT) ? {18'h0_0000, last_rs_r, 1'b0, state_r} : 32'h0000_0000;

   // software registers; hardware sets and steps win over software clears
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= CTRL_RST;
         usr_r <= '0;
         rq_ptr_r[0] <= PTR_RST;
         rq_ptr_r[1] <= PTR_RST;
      end
      else
      begin
         if (apb_wr && pa == OFF_CTRL) ctrl_r <= apb_in.pwdata[3:0];
         else if (go_clr) ctrl_r[CTRL_GO + 32'(ch_r)] <= 1'b0;
         if (apb_wr && pa == OFF_ATTN) usr_r <= usr_r & ~apb_in.pwdata[NCH-1:0];
         if (usr_set) usr_r[ch_r] <= 1'b1;
         if (apb_wr && pa == OFF_RQPTR0) rq_ptr_r[0] <= apb_in.pwdata[ADDR_W-1:0];
         if (apb_wr && pa == OFF_RQPTR1) rq_ptr_r[1] <= apb_in.pwdata[ADDR_W-1:0];
         if (rq_inc) rq_ptr_r[ch_r] <= rq_ptr_r[ch_r] + DESC_STEP;
      end
   end

   // restricted dialogue permission, held once a non-restricted token went by
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n) nr_seen_r <= 1'b0;
      else if (nonrestricted_token_passed) nr_seen_r <= 1'b1;
   end

   // descriptor engine
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         ch_r <= 1'b0;
         fetch_addr_r <= PTR_RST;
         w0_r <= 32'h0000_0000;
         req_tag_r <= TAG_LAST;
         req_loc_r <= PTR_RST;
         trc_r <= TRC_NONE;
         ccl_r <= 4'h0;
         uid_r <= 6'h00;
         frames_r <= SIZE_ZERO;
         odl_ptr_r <= PTR_RST;
         odl_start_r <= PTR_RST;
         od_cnt_r <= CNT_ZERO;
         prev_req_tag_r[0] <= TAG_LAST;
         prev_req_tag_r[1] <= TAG_LAST;
         prev_od_tag_r[0] <= TAG_LAST;
         prev_od_tag_r[1] <= TAG_LAST;
         obj_active_r <= 1'b0;
         token_held_r <= 1'b0;
         zero_end_r <= 1'b0;
         final_r <= 1'b0;
         rs_r <= RS_NONE;
         last_rs_r <= RS_NONE;
         odu_r <= '0;
      end
      else
      begin
         final_r <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               if (ctrl_r[CTRL_GO] || ctrl_r[CTRL_GO + 1])
               begin
                  ch_r <= !ctrl_r[CTRL_GO];
                  fetch_addr_r <= ctrl_r[CTRL_GO] ? rq_ptr_r[0] : rq_ptr_r[1];
                  state_r <= ST_RQ0;
               end
            end
            ST_RQ0:
            begin
               if (mem_rd_ack)
               begin
                  w0_r <= mem_rdata;
                  fetch_addr_r <= fetch_addr_r + WORD_STEP;
                  state_r <= ST_RQ1;
               end
            end
            ST_RQ1:
            begin
               if (mem_rd_ack)
               begin
                  req_tag_r <= tag_in;
                  req_loc_r <= {mem_rdata[ADDR_W-1:LOC_LSB], LOC_ZERO};
                  state_r <= ST_RCHK;
               end
            end
            ST_RCHK:
            begin
               if (req_first) uid_r <= w0_r[UID_LSB +: 6];
               if (req_err)
               begin
                  prev_req_tag_r[ch_r] <= TAG_LAST;
                  rs_r <= RS_CONSIST;
                  state_r <= ST_CNF;
               end
               else
               begin
                  prev_req_tag_r[ch_r] <= req_tag_r;
                  if (req_first)
                  begin
                     trc_r <= trc_in;
                     ccl_r <= ccl_in;
                     obj_active_r <= 1'b1;
                  end
                  if (req_first && incompat)
                  begin
                     rs_r <= RS_BAD_RINGOP;
                     state_r <= ST_CNF;
                  end
                  else if (size_in == SIZE_ZERO && !req_end)
                  begin
                     fetch_addr_r <= rq_ptr_r[ch_r];
                     state_r <= ST_RQ0;
                  end
                  else if (size_in == SIZE_ZERO && eff_imm)
                  begin
                     final_r <= 1'b1;
                     rs_r <= RS_OK;
                     state_r <= ST_CNF;
                  end
                  else
                  begin
                     zero_end_r <= size_in == SIZE_ZERO;
                     frames_r <= size_in;
                     odl_ptr_r <= req_loc_r;
                     odl_start_r <= req_loc_r;
                     fetch_addr_r <= req_loc_r;
                     state_r <= (eff_imm || token_held_r) && size_in != SIZE_ZERO ?
                        ST_OD0 : ST_TOKEN;
                  end
               end
            end
            ST_TOKEN:
            begin
               if (take_token)
               begin
                  token_held_r <= 1'b1;
                  if (zero_end_r)
                  begin
                     final_r <= 1'b1;
                     rs_r <= RS_OK;
                     state_r <= ST_CNF;
                  end
                  else state_r <= ST_OD0;
               end
            end
            ST_OD0:
            begin
               if (mem_rd_ack)
               begin
                  od_cnt_r <= cnt_in;
                  fetch_addr_r <= fetch_addr_r + WORD_STEP;
                  state_r <= ST_OD1;
               end
            end
            ST_OD1:
            begin
               if (mem_rd_ack && od_err)
               begin
                  prev_od_tag_r[ch_r] <= TAG_LAST;
                  rs_r <= RS_CONSIST;
                  state_r <= ST_CNF;
               end
               else if (mem_rd_ack)
               begin
                  prev_od_tag_r[ch_r] <= tag_in;
                  odl_ptr_r <= odl_ptr_r + DESC_STEP;
                  odu_r <= '{valid: 1'b1, addr: mem_rdata[ADDR_W-1:0],
                     byte_count: od_cnt_r, frame_end: tag_in[TAG_L],
                     last_frame: tag_in[TAG_L] && od_last_frame};
                  state_r <= ST_OSEND;
               end
            end
            ST_OSEND:
            begin
               if (odu_ready)
               begin
                  odu_r.valid <= 1'b0;
                  if (!odu_r.frame_end)
                  begin
                     fetch_addr_r <= odl_ptr_r;
                     state_r <= ST_OD0;
                  end
                  else if (repeat_on && go_ch)
                  begin
                     odl_ptr_r <= odl_start_r;
                     fetch_addr_r <= odl_start_r;
                     state_r <= ST_OD0;
                  end
                  else if (repeat_on || (frames_r == FRAME_ONE && req_end))
                  begin
                     rs_r <= RS_OK;
                     state_r <= ST_CNF;
                  end
                  else if (frames_r == FRAME_ONE)
                  begin
                     fetch_addr_r <= rq_ptr_r[ch_r];
                     state_r <= ST_RQ0;
                  end
                  else
                  begin
                     frames_r <= frames_r - FRAME_ONE;
                     fetch_addr_r <= odl_ptr_r;
                     state_r <= ST_OD0;
                  end
               end
            end
            ST_CNF:
            begin
               last_rs_r <= rs_r;
               obj_active_r <= 1'b0;
               token_held_r <= 1'b0;
               zero_end_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // checks on the engine
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_seq_abort_status: assert property (
      state_r == ST_RCHK && req_seq_err |=> state_r == ST_CNF && rs_r == RS_CONSIST ##1
      state_r == ST_IDLE && last_rs_r == RS_CONSIST)
      else $error("tag order fault not reported");
   a_zero_class_abort: assert property (
      state_r == ST_RCHK && req_first && trc_in == TRC_NONE |=> cnf_out.valid &&
      cnf_out.request_status == RS_CONSIST)
      else $error("zero class not aborted");
   a_bad_conf_class: assert property (
      state_r == ST_RCHK && req_first && ccl_bad |=> state_r == ST_CNF && cnf_out.valid)
      else $error("invalid confirmation class passed");
   a_usr_bit_set: assert property (
      usr_set |=> usr_r[$past(ch_r)] && rs_r == RS_BAD_RINGOP)
      else $error("unserviceable bit not set");
   a_class_presented: assert property (
      obj_active_r && state_r == ST_TOKEN |-> request_class_outputs == trc_r &&
      request_class_outputs != TRC_NONE)
      else $error("request class not presented");
   a_ready_zero_first: assert property (
      state_r != ST_TOKEN || zero_end_r |-> !request_ready)
      else $error("ready raised outside token wait");
   a_zero_end_final: assert property (
      take_token && zero_end_r |=> final_frame_signal && state_r == ST_CNF)
      else $error("final missing on zero count end");
   a_rq_ptr_step: assert property (
      rq_inc |=> rq_ptr_r[$past(ch_r)] == $past(rq_ptr_r[ch_r]) + DESC_STEP)
      else $error("request pointer did not step");
   a_odl_ptr_step: assert property (
      od_inc |=> odl_ptr_r == $past(odl_ptr_r) + DESC_STEP && odu_out.valid)
      else $error("list pointer did not step");
   a_output_unit_descriptor_zero_first: assert property (
      state_r == ST_OD1 && mem_rd_ack && od_first && od_cnt_r == CNT_ZERO |=>
      rs_r == RS_CONSIST [*2])
      else $error("zero count first descriptor accepted");

   c_completed_ok: cover property (cnf_out.valid && cnf_out.request_status == RS_OK);
   c_consist_abort: cover property (cnf_out.valid && cnf_out.request_status == RS_CONSIST);
   c_repeat_restart: cover property (state_r == ST_OSEND && odu_ready && repeat_on && go_ch);
   c_zero_final: cover property (take_token && zero_end_r);
endmodule // request_descriptor_checker

// ===== verification/host_mem_model.sv
// Purpose: host memory and MAC stand-in for the request descriptor checker
// Assumes: the bench presets descriptor words in mem before starting a channel
// Notes: latency and token timing are random so slow partners get exercised
`timescale 1ns/1ps
module host_mem_model
   import rdc_pkg::*;
(
   input wire logic clk_sys,
   input wire rdc_pkg::mem_rd_s mem_rd,
   output logic mem_rd_ack,
   output logic [31:0] mem_rdata,
   output logic odu_ready,
   output logic token_captured,
   output logic nonrestricted_token_passed
);
   logic [31:0] mem [logic [27:0]];
   int wait_n = 0;
   // read data is scrambled outside the ack cycle so stale words never match
   always @(posedge clk_sys)
   begin
      token_captured <= 1'($urandom % 2);
      odu_ready <= 1'($urandom % 2);
      nonrestricted_token_passed <= ($urandom % 8 == 0);
      mem_rd_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd.valid === 1'b1 && mem_rd_ack !== 1'b1)
      begin
         if (wait_n > 0)
            wait_n <= wait_n - 1;
         else
         begin
            mem_rd_ack <= 1'b1;
            mem_rdata <= mem.exists(mem_rd.addr) ? mem[mem_rd.addr] : 32'h5A5A_A5A5;
            wait_n <= $urandom % 3;
         end
      end
   end
endmodule // host_mem_model

// ===== verification/tb_request_descriptor_checker.sv
// Purpose: self-checking bench for the request descriptor checker
// Assumes: single-part requests, one of them with a one-frame list; ring events clear
// Notes: expected status comes from a small integer model of the checks
`timescale 1ns/1ps
module tb_request_descriptor_checker;
   import rdc_pkg::*;
   logic clk_sys = 0, resetn = 0, ring_operational = 0, err;
   logic mem_rd_ack, odu_ready, token_captured, nonrestricted_token_passed, pready, pslverr;
   logic request_ready, final_frame_signal, tht_enable, got_fin, got_tht;
   logic [31:0] prdata, mem_rdata, q;
   logic [3:0] request_class_outputs, got_rs, got_rco;
   logic [5:0] got_uid;
   logic [12:0] got_cnt;
   apb_req_s apb_in = '0;
   mem_rd_s mem_rd;
   odu_s odu_out;
   cnf_s cnf_out;
   int fails = 0, comparisons = 0, cycles = 0, n_cnf = 0;
   request_descriptor_checker u_request_descriptor_checker (.clk_sys(clk_sys), .resetn(resetn),
      .apb_in(apb_in), .pready(pready), .prdata(prdata), .pslverr(pslverr), .mem_rd(mem_rd),
      .mem_rd_ack(mem_rd_ack), .mem_rdata(mem_rdata), .odu_out(odu_out), .odu_ready(odu_ready),
      .cnf_out(cnf_out), .request_class_outputs(request_class_outputs),
      .request_ready(request_ready), .final_frame_signal(final_frame_signal),
      .tht_enable(tht_enable), .claim_request(), .beacon_request(), .imm_from_claim(),
      .imm_from_beacon(), .token_captured(token_captured),
      .nonrestricted_token_passed(nonrestricted_token_passed),
      .ring_operational(ring_operational), .beacon_received_bit(1'b0),
      .claim_received_bit(1'b0), .other_mac_frame_bit(1'b0));
   host_mem_model u_host_mem_model (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_rd_ack(mem_rd_ack),
      .mem_rdata(mem_rdata), .odu_ready(odu_ready), .token_captured(token_captured),
      .nonrestricted_token_passed(nonrestricted_token_passed));
   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      apb_in <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk_sys);
      apb_in.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      apb_in <= '0;
      @(posedge clk_sys);
   endtask
   // results seen at the mac and confirmation ports
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cnf_out.valid === 1'b1)
      begin
         n_cnf++;
         got_rs = cnf_out.request_status;
         got_uid = cnf_out.user_identification;
      end
      if (final_frame_signal === 1'b1)
      begin
         got_fin = 1'b1;
         got_rco = request_class_outputs;
         got_tht = tht_enable;
      end
      if (odu_out.valid === 1'b1 && odu_ready === 1'b1) got_cnt = odu_out.byte_count;
      if (cycles == 40000)
      begin
         fails++;
         complete_run();
      end
   end
   // one single-part request of zero or one frame; the model mirrors the descriptor checks
   task automatic run_req(input logic [31:0] w0, input logic [31:0] w1, input int idx);
      logic [27:0] base = 28'(idx * 16);
      int exp, ecnf, trc = w0[11:8], ccl = w0[15:12];
      u_host_mem_model.mem[base] = w0;
      u_host_mem_model.mem[base + 4] = w1;
      if (w0[23:16] != 8'h00)
      begin
         u_host_mem_model.mem[base + 8] = 32'(4 + $urandom % 8);
         u_host_mem_model.mem[base + 12] = 32'hC000_0100;
      end
      if (!w1[31] || trc == 0 || (ccl & 7) == 0 || (ccl & 3) == 2)
         exp = 14;
      else if (trc == 2 || trc == 3 || (trc >= 5 && trc <= 7 && ring_operational))
         exp = 10;
      else
         exp = 6;
      // no status word on a clean end unless completion confirmations are on
      ecnf = exp != 6 || ccl % 2 == 1;
      n_cnf = 0;
      got_fin = 0;
      apb_xfer(1'b1, OFF_RQPTR0, 32'(base));
      apb_xfer(1'b1, OFF_CTRL, {28'h000_0000, 1'b0, 1'($urandom % 2), 2'h1});
      for (int w = 0; w < 600 && n_cnf == 0; w++) @(posedge clk_sys);
      check(32'(n_cnf), 32'(ecnf));
      if (ecnf) check(32'(got_rs), 32'(exp));
      if (ecnf && w1[31]) check(32'(got_uid), 32'(w0[29:24]));
      if (w0[23:16] != 8'h00) check(32'(got_cnt), u_host_mem_model.mem[base + 8]);
      check(32'(got_fin), 32'(exp == 6));
      if (exp == 6) check(32'(got_rco), 32'(trc));
      if (exp == 6) check(32'(got_tht), 32'(trc == 1 || (trc >= 8 && trc <= 11)));
      apb_xfer(1'b0, OFF_RQPTR0, 32'h0000_0000);
      check(q, 32'(base + 8));
      apb_xfer(1'b0, OFF_STAT, 32'h0000_0000);
      check(32'(q[13:10]), 32'(exp));
      if (w0[23:16] != 8'h00)
      begin
         apb_xfer(1'b0, OFF_ODLPTR, 32'h0000_0000);
         check(q, 32'(base + 16));
      end
      apb_xfer(1'b0, OFF_ATTN, 32'h0000_0000);
      check(32'(q[0]), 32'(exp == 10));
      if (q[0] === 1'b1) apb_xfer(1'b1, OFF_ATTN, 32'h0000_0001);
      $display("test %0d done status %h", idx, exp);
   endtask
   initial
   begin
      logic [3:0] trc, ccl;
      logic [1:0] tag;
      void'($urandom(35));
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      apb_xfer(1'b0, OFF_CTRL, 32'h0000_0000);
      check(q, 32'(CTRL_RST));
      apb_xfer(1'b0, 8'h40, 32'h0000_0000);
      check({q[30:0], err}, 32'h0000_0001);
      for (int i = 0; i < 21; i++)
      begin
         trc = (i < 16) ? 4'(i) : 4'h8;
         ccl = {1'b0, 2'($urandom % 4), 1'b1};
         tag = (i == 16) ? 2'h0 : (i == 17) ? 2'h1 : 2'h3;
         if (i >= 18) ccl = (i == 18) ? 4'h2 : (i == 19) ? 4'h4 : 4'h1;
         ring_operational <= 1'($urandom % 2);
         @(posedge clk_sys);
         run_req({2'h0, 6'($urandom), 8'(i == 20), ccl, trc, 8'h00},
            {tag, 2'h0, 28'(i * 16 + 8)}, i);
      end
      complete_run();
   end
endmodule // tb_request_descriptor_checker
